// ===== common/pam_port_regs.svh
`ifndef PAM_PORT_REGS_SVH
`define PAM_PORT_REGS_SVH

// ------------------------------------------------------------
// pin positions of the upper port a slice
// ------------------------------------------------------------
`define PAM_PIN_LO 2
`define PAM_PIN_HI 7
`define PAM_A7 7
`define PAM_A6 6
`define PAM_A5 5
`define PAM_A4 4
`define PAM_A3 3
`define PAM_A2 2

// ------------------------------------------------------------
// reset values: drivers off, pull-ups off, no pin change seen
// ------------------------------------------------------------
`define PAM_RST_PINS 6'h00
`define PAM_RST_BIT 1'h0

// ------------------------------------------------------------
// synchroniser depth on pad inputs
// ------------------------------------------------------------
`define PAM_SYNC_STAGES 2

`endif

// ===== common/pam_pkg.sv
`default_nettype none

package pam_pkg;

   // role of the spi as seen by the pin overrides
   typedef enum logic [1:0]
   {
      pam_role_off = 2'b00,
      pam_role_slave = 2'b01,
      pam_role_master = 2'b10
   } pam_spi_role_t;

endpackage

`default_nettype wire

// ===== rtl/pam_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for asynchronous pad levels
module pam_sync
#(
   parameter int WIDTH = 6
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // asynchronous levels in, synchronised levels out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // first stage is read only by the second stage
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;

endmodule

`default_nettype wire

// ===== rtl/pam_pin_cell.sv
`timescale 1ns/10ps
`default_nettype none

// generic override cell for one port pin
module pam_pin_cell
(
   // ordinary port controls
   input wire logic dir_bit,
   input wire logic out_bit,
   input wire logic pud_any,
   // override enables and values
   input wire logic puoe,
   input wire logic puov,
   input wire logic ddoe,
   input wire logic ddov,
   input wire logic pvoe,
   input wire logic pvov,
   // resolved pad controls
   output logic oe,
   output logic val,
   output logic pu
);

   // an override enable hands the control to its value, else the port bits rule
   assign oe = ddoe ? ddov : dir_bit;
   assign val = pvoe ? pvov : out_bit;
   // default pull-up needs input, out bit one and no disable
   assign pu = puoe ? puov : (~dir_bit & out_bit & ~pud_any);

endmodule

`default_nettype wire

// ===== rtl/pam_port_a_upper.sv
`timescale 1ns/10ps
`default_nettype none
`include "pam_port_regs.svh"

// Overview of operation
// - reference drives pin a7 only if output enabled and internal reference selected.
// - while reference is output on a7, pull-up and output driver are off.
// - external reference or bypass capacitor use on a7 disables pull-up and driver.
// - spi slave forces pin a6 slave select to input.
// - slave spi is active only while slave select is low; master drives it.
// - spi master leaves a6 direction to its direction bit.
// - forced-input a6 still takes its pull-up from its out bit.
// - spi slave forces pin a5 clock to input.
// - spi master lets a5 direction bit decide if clock is driven.
// - forced-input a5 keeps its pull-up under its out bit.
// - spi slave forces mosi pin to input; master lets direction bit govern.
// - forced-input mosi pin keeps its pull-up under its out bit.
// - three-wire mode leaves the data input pin direction and pull-up alone.
// - timer0 compare output reaches a2 only when its direction bit is output.
// - three-wire mode with spi disabled puts serial data out on a2 when direction is output.
// - three-wire mode with a2 input and out bit one enables its pull-up.
// - spi master forces a2 miso to input.
// - spi slave lets a2 direction bit decide if slave data is driven.
// - forced-input a2 keeps its pull-up under its out bit.
// - each port pin n feeds pin change source n.
// - default pull-up needs input direction, out bit one, pull-up disable clear.
// - global and port-wise pull-up disables are ored before use.
module pam_port_a_upper
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // pad levels, asynchronous
   input wire logic [7:2] pad_in,
   // port register bits
   input wire logic [7:2] pin_direction_bit,
   input wire logic [7:2] pin_output_bit,
   input wire logic global_pullup_disable,
   input wire logic portwise_pullup_disable,
   // reference controls
   input wire logic ref_output_enable,
   input wire logic ref_internal_selected,
   input wire logic external_ref_input,
   input wire logic ref_bypass_only,
   // spi controls and outputs
   input wire logic spi_enable,
   input wire logic spi_master_select,
   input wire logic spi_clock_out,
   input wire logic spi_mosi_out,
   input wire logic spi_miso_out,
   // serial unit and timer
   input wire logic three_wire_mode,
   input wire logic serial_shift_out,
   input wire logic timer0_compare_en,
   input wire logic timer0_compare_out_a,
   // pad controls
   output logic [7:2] pad_out_en,
   output logic [7:2] pad_out_val,
   output logic [7:2] pad_pullup_en,
   // alternate function status
   output logic internal_ref_output,
   output logic spi_slave_active,
   output logic [7:2] pin_change_source
);

   // ---------------------------------------------------------
   // decode of the spi role and pull-up disable
   // ---------------------------------------------------------
   pam_pkg::pam_spi_role_t spi_role;
   logic pud_any;
   logic spi_slave;
   logic spi_master;
   logic [7:2] pad_sync;

   // role follows the enable and master select with no delay
   assign spi_role = !spi_enable ? pam_pkg::pam_role_off :
                     (spi_master_select ? pam_pkg::pam_role_master :
                      pam_pkg::pam_role_slave);
   assign spi_slave = (spi_role == pam_pkg::pam_role_slave);
   assign spi_master = (spi_role == pam_pkg::pam_role_master);
   assign pud_any = global_pullup_disable | portwise_pullup_disable;

   // ---------------------------------------------------------
   // pad input synchroniser
   // ---------------------------------------------------------
   pam_sync
   #(
      .WIDTH(`PAM_PIN_HI - `PAM_PIN_LO + 1)
   )
   u_sync
   (
      .sys_clk(sys_clk),
      .srst(srst),
      .async_in(pad_in),
      .sync_out(pad_sync)
   );

   // ---------------------------------------------------------
   // per-pin override decode
   // ---------------------------------------------------------
   logic [7:2] puoe;
   logic [7:2] puov;
   logic [7:2] ddoe;
   logic [7:2] ddov;
   logic [7:2] pvoe;
   logic [7:2] pvov;
   logic ref_out_on;
   logic a7_analog;
   logic a2_serial;

   // reference only leaves the chip when it is the one in use
   assign ref_out_on = ref_output_enable & ref_internal_selected;
   // any analog reference role parks the digital side of a7
   assign a7_analog = ref_out_on | external_ref_input | ref_bypass_only;
   assign puoe[`PAM_A7] = a7_analog;
   assign puov[`PAM_A7] = `PAM_RST_BIT;
   assign ddoe[`PAM_A7] = a7_analog;
   assign ddov[`PAM_A7] = `PAM_RST_BIT;
   assign pvoe[`PAM_A7] = `PAM_RST_BIT;
   assign pvov[`PAM_A7] = `PAM_RST_BIT;

   // slave select: forced input as slave, pull-up stays with the out bit
   assign ddoe[`PAM_A6] = spi_slave;
   assign ddov[`PAM_A6] = `PAM_RST_BIT;
   assign puoe[`PAM_A6] = spi_slave;
   assign puov[`PAM_A6] = pin_output_bit[`PAM_A6] & ~pud_any;
   assign pvoe[`PAM_A6] = `PAM_RST_BIT;
   assign pvov[`PAM_A6] = `PAM_RST_BIT;

   // spi clock: slave forces input, master drives the clock if dir allows
   assign ddoe[`PAM_A5] = spi_slave;
   assign ddov[`PAM_A5] = `PAM_RST_BIT;
   assign puoe[`PAM_A5] = spi_slave;
   assign puov[`PAM_A5] = pin_output_bit[`PAM_A5] & ~pud_any;
   assign pvoe[`PAM_A5] = spi_master;
   assign pvov[`PAM_A5] = spi_clock_out;

   // mosi: same pattern; three-wire data input adds no override at all
   assign ddoe[`PAM_A4] = spi_slave;
   assign ddov[`PAM_A4] = `PAM_RST_BIT;
   assign puoe[`PAM_A4] = spi_slave;
   assign puov[`PAM_A4] = pin_output_bit[`PAM_A4] & ~pud_any;
   assign pvoe[`PAM_A4] = spi_master;
   assign pvov[`PAM_A4] = spi_mosi_out;

   // a3 carries only analog and interrupt roles here
   assign puoe[`PAM_A3] = `PAM_RST_BIT;
   assign puov[`PAM_A3] = `PAM_RST_BIT;
   assign ddoe[`PAM_A3] = `PAM_RST_BIT;
   assign ddov[`PAM_A3] = `PAM_RST_BIT;
   assign pvoe[`PAM_A3] = `PAM_RST_BIT;
   assign pvov[`PAM_A3] = `PAM_RST_BIT;

   // miso: spi wins over serial data, serial data over timer compare
   assign a2_serial = three_wire_mode & ~spi_enable;
   assign ddoe[`PAM_A2] = spi_master;
   assign ddov[`PAM_A2] = `PAM_RST_BIT;
   assign puoe[`PAM_A2] = spi_master;
   assign puov[`PAM_A2] = pin_output_bit[`PAM_A2] & ~pud_any;
   assign pvoe[`PAM_A2] = spi_slave | a2_serial | timer0_compare_en;
   assign pvov[`PAM_A2] = spi_slave ? spi_miso_out :
                          (a2_serial ? serial_shift_out :
                           timer0_compare_out_a);

   // ---------------------------------------------------------
   // override cells, one per pin
   // ---------------------------------------------------------
   logic [7:2] nxt_pad_out_en;
   logic [7:2] nxt_pad_out_val;
   logic [7:2] nxt_pad_pullup_en;

   // a pin with no override falls back to the ordinary port rules
   genvar gi;
   generate
      for (gi = `PAM_PIN_LO; gi <= `PAM_PIN_HI; gi++)
      begin : g_pin
         pam_pin_cell u_cell
         (
            .dir_bit(pin_direction_bit[gi]),
            .out_bit(pin_output_bit[gi]),
            .pud_any(pud_any),
            .puoe(puoe[gi]),
            .puov(puov[gi]),
            .ddoe(ddoe[gi]),
            .ddov(ddov[gi]),
            .pvoe(pvoe[gi]),
            .pvov(pvov[gi]),
            .oe(nxt_pad_out_en[gi]),
            .val(nxt_pad_out_val[gi]),
            .pu(nxt_pad_pullup_en[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------
   // status decode
   // ---------------------------------------------------------
   logic nxt_spi_slave_active;

   // slave select is low-active; synchronised copy avoids metastable spi enable
   assign nxt_spi_slave_active = spi_slave & ~pad_sync[`PAM_A6];

   // ---------------------------------------------------------
   // output registers
   // ---------------------------------------------------------
   logic [7:2] pad_out_en_ff;
   logic [7:2] pad_out_val_ff;
   logic [7:2] pad_pullup_en_ff;
   logic internal_ref_output_ff;
   logic spi_slave_active_ff;
   logic [7:2] pin_change_source_ff;

   // one register stage so the pads see glitch-free controls;
   // costs a cycle of latency on every override change
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         pad_out_en_ff <= `PAM_RST_PINS;
         pad_out_val_ff <= `PAM_RST_PINS;
         pad_pullup_en_ff <= `PAM_RST_PINS;
         internal_ref_output_ff <= `PAM_RST_BIT;
         spi_slave_active_ff <= `PAM_RST_BIT;
         pin_change_source_ff <= `PAM_RST_PINS;
      end
      else
      begin
         pad_out_en_ff <= nxt_pad_out_en;
         pad_out_val_ff <= nxt_pad_out_val;
         pad_pullup_en_ff <= nxt_pad_pullup_en;
         internal_ref_output_ff <= ref_out_on;
         spi_slave_active_ff <= nxt_spi_slave_active;
         pin_change_source_ff <= pad_sync;
      end
   end

   assign pad_out_en = pad_out_en_ff;
   assign pad_out_val = pad_out_val_ff;
   assign pad_pullup_en = pad_pullup_en_ff;
   assign internal_ref_output = internal_ref_output_ff;
   assign spi_slave_active = spi_slave_active_ff;
   assign pin_change_source = pin_change_source_ff;

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   // slave select held low at the pad for three edges
   sequence ss_low_held;
      (spi_slave && !pad_in[`PAM_A6]) [*3];
   endsequence

   ref_out_route_a: assert property ($past(ref_out_on) |-> internal_ref_output)
      else $error("reference output not routed");
   ref_pin_off_a: assert property (
      $past(a7_analog) |-> (!pad_out_en[`PAM_A7] && !pad_pullup_en[`PAM_A7]))
      else $error("a7 driver or pull-up on in reference use");
   ext_ref_off_a: assert property (
      $past(external_ref_input | ref_bypass_only) |-> !pad_out_en[`PAM_A7])
      else $error("a7 driver on with external reference");
   ss_forced_in_a: assert property ($past(spi_slave) |-> !pad_out_en[`PAM_A6])
      else $error("slave select not forced to input");
   ss_active_a: assert property (ss_low_held |=> spi_slave_active)
      else $error("slave spi not active with select low");
   ss_master_dir_a: assert property (
      $past(spi_master) |-> pad_out_en[`PAM_A6] == $past(pin_direction_bit[`PAM_A6]))
      else $error("a6 direction overridden in master mode");
   ss_pullup_a: assert property ($past(spi_slave) |->
      pad_pullup_en[`PAM_A6] == $past(pin_output_bit[`PAM_A6] & ~pud_any))
      else $error("a6 pull-up not under out bit");
   sck_slave_in_a: assert property ($past(spi_slave) |-> !pad_out_en[`PAM_A5])
      else $error("spi clock pin not forced to input");
   sck_master_out_a: assert property ($past(spi_master && pin_direction_bit[`PAM_A5]) |->
      pad_out_en[`PAM_A5] && pad_out_val[`PAM_A5] == $past(spi_clock_out))
      else $error("spi clock not driven in master mode");
   mosi_slave_in_a: assert property ($past(spi_slave) |-> !pad_out_en[`PAM_A4])
      else $error("mosi pin not forced to input");
   timer_dir_a: assert property ($past(!pin_direction_bit[`PAM_A2] && !spi_master &&
      !spi_slave) |-> !pad_out_en[`PAM_A2])
      else $error("a2 driven while direction is input");
   serial_out_a: assert property ($past(a2_serial && pin_direction_bit[`PAM_A2]) |->
      pad_out_en[`PAM_A2] && pad_out_val[`PAM_A2] == $past(serial_shift_out))
      else $error("serial data not on a2");
   miso_master_in_a: assert property ($past(spi_master) |-> !pad_out_en[`PAM_A2])
      else $error("miso not forced to input");
   pullup_dflt_a: assert property ($past(!spi_enable && !a7_analog) |->
      pad_pullup_en == $past(~pin_direction_bit & pin_output_bit & {6{~pud_any}}))
      else $error("default pull-up wrong");
   pin_change_a: assert property (
      $stable(pad_in) [*3] |=> pin_change_source == $past(pad_in))
      else $error("pin change source not following pad");
   sck_pullup_a: assert property ($past(spi_slave) |->
      pad_pullup_en[`PAM_A5] == $past(pin_output_bit[`PAM_A5] & ~pud_any))
      else $error("a5 pull-up not under out bit");
   mosi_pullup_a: assert property ($past(spi_slave) |->
      pad_pullup_en[`PAM_A4] == $past(pin_output_bit[`PAM_A4] & ~pud_any))
      else $error("a4 pull-up not under out bit");
   miso_pullup_a: assert property ($past(spi_master) |->
      pad_pullup_en[`PAM_A2] == $past(pin_output_bit[`PAM_A2] & ~pud_any))
      else $error("a2 pull-up not under out bit");
   miso_slave_out_a: assert property ($past(spi_slave && pin_direction_bit[`PAM_A2]) |->
      pad_out_en[`PAM_A2] && pad_out_val[`PAM_A2] == $past(spi_miso_out))
      else $error("slave data not driven on a2");
   serial_pullup_a: assert property ($past(a2_serial && !pin_direction_bit[`PAM_A2] &&
      pin_output_bit[`PAM_A2] && !pud_any) |-> pad_pullup_en[`PAM_A2])
      else $error("a2 pull-up off in three-wire input");
   pud_or_a: assert property ($past((global_pullup_disable || portwise_pullup_disable) &&
      !spi_enable) |-> pad_pullup_en == `PAM_RST_PINS)
      else $error("pull-up on while a disable is set");

endmodule

`default_nettype wire

// ===== dv/pam_spi_peer.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// external spi master seen on the slave select pad
// ----------------------------------------
module pam_spi_peer
(
   // clock
   input wire logic sys_clk,
   // bench request and pad pull-up state
   input wire logic select_req,
   input wire logic pullup_en,
   // slave select line at the pad
   output logic ss_line
);
   logic toggle_ff = 1'b0;

   // a floating line must not read as a steady level, so it changes each cycle
   // plain always: the declaration already gives the start value
   always @(posedge sys_clk)
   begin
      toggle_ff <= ~toggle_ff;
   end

   // master pulls select low to address the slave, else pull-up or float
   assign ss_line = select_req ? 1'b0 : (pullup_en ? 1'b1 : toggle_ff);
endmodule

`default_nettype wire

// ===== dv/pam_port_a_upper_bench.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// bench for the upper port a override mux
// ----------------------------------------
module pam_port_a_upper_bench;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [7:2] tb_pad = 6'h00;
   logic [7:2] dir = 6'h00;
   logic [7:2] outb = 6'h00;
   logic gpud = 1'b0;
   logic ppud = 1'b0;
   logic ref_en = 1'b0;
   logic ref_int = 1'b0;
   logic ref_ext = 1'b0;
   logic ref_byp = 1'b0;
   logic spe = 1'b0;
   logic mstr = 1'b0;
   logic sck = 1'b0;
   logic mosi = 1'b0;
   logic miso = 1'b0;
   logic tw = 1'b0;
   logic sho = 1'b0;
   logic t0en = 1'b0;
   logic t0 = 1'b0;
   logic sel = 1'b0;
   logic [7:2] pad_in;
   logic [7:2] oe;
   logic [7:2] val;
   logic [7:2] pu;
   logic [7:2] pcs;
   logic ss_line;
   logic iref;
   logic sact;
   int n_errors = 0;
   int checks_done = 0;

   // slave select pad comes from the peer, the rest from the bench
   assign pad_in = {tb_pad[7], ss_line, tb_pad[5:2]};

   // 200 mhz clock
   initial
   begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   pam_port_a_upper i_pam_port_a_upper
   (
      .sys_clk(sys_clk), .srst(srst), .pad_in(pad_in),
      .pin_direction_bit(dir), .pin_output_bit(outb),
      .global_pullup_disable(gpud), .portwise_pullup_disable(ppud),
      .ref_output_enable(ref_en), .ref_internal_selected(ref_int),
      .external_ref_input(ref_ext), .ref_bypass_only(ref_byp),
      .spi_enable(spe), .spi_master_select(mstr), .spi_clock_out(sck),
      .spi_mosi_out(mosi), .spi_miso_out(miso), .three_wire_mode(tw),
      .serial_shift_out(sho), .timer0_compare_en(t0en),
      .timer0_compare_out_a(t0), .pad_out_en(oe), .pad_out_val(val),
      .pad_pullup_en(pu), .internal_ref_output(iref),
      .spi_slave_active(sact), .pin_change_source(pcs)
   );

   pam_spi_peer i_pam_spi_peer
   (
      .sys_clk(sys_clk), .select_req(sel), .pullup_en(pu[6]), .ss_line(ss_line)
   );

   // compare one value, count it, report a mismatch at once
   task chk(input string name, input logic [5:0] exp, input logic [5:0] seen);
      begin
         checks_done++;
         if (seen !== exp)
         begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
         end
      end
   endtask

   // outputs are registered: let n edges pass, then sample at the falling edge
   task go(input int n);
      begin
         repeat (n) @(posedge sys_clk);
         @(negedge sys_clk);
      end
   endtask

   task results();
      begin
         $display("checks %0d errors %0d", checks_done, n_errors);
         if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // hang guard, far beyond the roughly 45 cycles the tests need
   initial
   begin
      repeat (1000) @(posedge sys_clk);
      n_errors++;
      results();
   end

   initial
   begin
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("oe rst", 6'h00, oe);
      chk("pu rst", 6'h00, pu);
      srst = 1'b0;
      // plain port behaviour and pull-up disables
      outb = 6'h3f;
      go(1);
      chk("pu", 6'h3f, pu);
      chk("oe", 6'h00, oe);
      gpud = 1'b1;
      go(1);
      chk("pu gpud", 6'h00, pu);
      gpud = 1'b0;
      ppud = 1'b1;
      go(1);
      chk("pu ppud", 6'h00, pu);
      ppud = 1'b0;
      dir = 6'h3f;
      outb = 6'h2a;
      go(1);
      chk("oe", 6'h3f, oe);
      chk("val", 6'h2a, val);
      chk("pu", 6'h00, pu);
      // reference pin
      ref_en = 1'b1;
      ref_int = 1'b1;
      outb = 6'h3f;
      go(1);
      chk("iref", 6'h01, {5'h00, iref});
      chk("oe ref", 6'h1f, oe);
      dir = 6'h00;
      go(1);
      chk("pu ref", 6'h1f, pu);
      ref_int = 1'b0;
      go(1);
      chk("iref", 6'h00, {5'h00, iref});
      ref_en = 1'b0;
      ref_ext = 1'b1;
      go(1);
      chk("pu ext", 6'h1f, pu);
      dir = 6'h3f;
      go(1);
      chk("oe ext", 6'h1f, oe);
      ref_ext = 1'b0;
      ref_byp = 1'b1;
      go(1);
      chk("oe byp", 6'h1f, oe);
      dir = 6'h00;
      go(1);
      chk("pu byp", 6'h1f, pu);
      ref_byp = 1'b0;
      // spi slave
      spe = 1'b1;
      dir = 6'h3f;
      miso = 1'b1;
      go(1);
      chk("oe slv", 6'h23, oe);
      chk("pu slv", 6'h1c, pu);
      chk("val slv", 6'h21, val & 6'h21);
      miso = 1'b0;
      dir = 6'h3e;
      go(1);
      chk("val slv", 6'h20, val & 6'h21);
      chk("oe slv", 6'h22, oe);
      gpud = 1'b1;
      go(1);
      chk("pu slv", 6'h00, pu);
      gpud = 1'b0;
      // spi master
      mstr = 1'b1;
      dir = 6'h3f;
      sck = 1'b1;
      miso = 1'b1;
      go(1);
      chk("oe mst", 6'h3e, oe);
      chk("val mst", 6'h3a, val & 6'h3e);
      chk("pu mst", 6'h01, pu);
      sck = 1'b0;
      mosi = 1'b1;
      go(1);
      chk("val mst", 6'h36, val & 6'h3e);
      dir = 6'h00;
      go(1);
      chk("oe mst", 6'h00, oe);
      chk("pu mst", 6'h3f, pu);
      ppud = 1'b1;
      go(1);
      chk("pu mst", 6'h00, pu);
      ppud = 1'b0;
      // three-wire serial unit
      spe = 1'b0;
      mstr = 1'b0;
      tw = 1'b1;
      dir = 6'h05;
      go(1);
      chk("oe tw", 6'h05, oe);
      chk("val tw", 6'h04, val & 6'h05);
      chk("pu tw", 6'h3a, pu);
      sho = 1'b1;
      go(1);
      chk("val tw", 6'h05, val & 6'h05);
      dir = 6'h00;
      go(1);
      chk("pu tw", 6'h3f, pu);
      chk("oe tw", 6'h00, oe);
      // timer compare output
      tw = 1'b0;
      t0en = 1'b1;
      t0 = 1'b1;
      dir = 6'h01;
      outb = 6'h00;
      go(1);
      chk("oe t0", 6'h01, oe);
      chk("val t0", 6'h01, val & 6'h01);
      t0 = 1'b0;
      go(1);
      chk("val t0", 6'h00, val & 6'h01);
      t0 = 1'b1;
      dir = 6'h00;
      go(1);
      chk("oe t0", 6'h00, oe);
      t0en = 1'b0;
      // pad sampling and slave select through the peer
      spe = 1'b1;
      outb = 6'h3f;
      go(4);
      chk("sact", 6'h00, {5'h00, sact});
      tb_pad = 6'h15;
      sel = 1'b1;
      go(2);
      chk("pcs", 6'h10, pcs);
      go(1);
      chk("pcs", 6'h05, pcs);
      chk("sact", 6'h01, {5'h00, sact});
      mstr = 1'b1;
      tb_pad = 6'h2a;
      go(1);
      chk("sact", 6'h00, {5'h00, sact});
      go(2);
      chk("pcs", 6'h2a, pcs);
      results();
   end
endmodule

`default_nettype wire
